// ==== pkg/tpwm_pkg.sv ====
// constants for the triggered pwm timer block
package tpwm_pkg;
  // register indices on the plain register port
  localparam logic [3:0] TPWM_A_CTL0 = 4'h0;
  localparam logic [3:0] TPWM_A_CTL1 = 4'h1;
  localparam logic [3:0] TPWM_A_OUTC = 4'h2;
  localparam logic [3:0] TPWM_A_EDGE = 4'h3;
  localparam logic [3:0] TPWM_A_CNT = 4'h4;
  localparam logic [3:0] TPWM_A_CMP0 = 4'h5;
  localparam logic [3:0] TPWM_A_CMP1 = 4'h6;
  localparam logic [3:0] TPWM_A_CMP2 = 4'h7;
  localparam logic [3:0] TPWM_A_CMP3 = 4'h8;
  // timer_control_zero fields
  localparam int TPWM_B_CE = 7;
  localparam int TPWM_B_CKS = 0;
  // timer_control_one fields
  localparam int TPWM_B_EST = 6;
  localparam int TPWM_B_EEE = 5;
  localparam int TPWM_B_MD = 0;
  // output_control fields: enable at 2k, level at 2k+1
  localparam int TPWM_B_OE0 = 0;
  localparam int TPWM_B_OL0 = 1;
  // edge_select fields
  localparam int TPWM_B_ETS = 0;
  localparam int TPWM_B_EES = 2;
  // mode codes
  localparam logic [2:0] TPWM_MD_EVENT = 3'h1;
  localparam logic [2:0] TPWM_MD_PWM = 3'h2;
  // edge codes
  localparam logic [1:0] TPWM_EDG_NONE = 2'h0;
  localparam logic [1:0] TPWM_EDG_RISE = 2'h1;
  localparam logic [1:0] TPWM_EDG_FALL = 2'h2;
  localparam logic [1:0] TPWM_EDG_BOTH = 2'h3;
  // reset and idle values
  localparam logic [7:0] TPWM_RST_REG8 = 8'h00;
  localparam logic [15:0] TPWM_RST_CMP = 16'h0000;
  localparam logic [15:0] TPWM_CNT_IDLE = 16'hffff;
  localparam logic [15:0] TPWM_CNT_ZERO = 16'h0000;
  localparam logic [7:0] TPWM_DIV_ONE = 8'h01;
  typedef enum logic [1:0] {TPWM_ST_IDLE, TPWM_ST_WAIT, TPWM_ST_RUN} tpwm_state_e;
endpackage

// ==== hw/tpwm_timer.sv ====
// triggered pwm timer with register port, counter, compare buffers and outputs
`timescale 1ns/1ps
// What this block does
// - secondary below period: one irq per cycle
// - secondary above period: irq never raised
// - mode bits 010 select triggered pwm
// - enable waits for trigger before counting in pwm mode
// - trigger is input edge or software bit
// - first trigger clears ffff to zero, starts
// - retrigger clears counter, toggles, drives high
// - active width equals channel compare value
// - period equals period compare plus one
// - primary toggles once per pwm cycle
// - period irq on step clearing counter
// - width irq when counter equals buffer
// - buffers reload only at cycle wrap or on start from idle
// - writing compare one arms the reload
// - eee zero uses selected internal clock outside event mode
// - primary enable and idle level bits
// - secondary enable and active level bits
// - edge select for trigger and event inputs
// - counter readback returns live counter
module tpwm_timer
  import tpwm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // external inputs
  input wire logic trigger_in,
  input wire logic event_in,
  // outputs
  output logic primary_output_pin,
  output logic [2:0] secondary_output_pin,
  output logic period_match_irq,
  output logic [2:0] width_match_irq
);
  import tpwm_pkg::*;

  logic [7:0] timer_control_zero;
  logic [7:0] timer_control_one;
  logic [7:0] output_control;
  logic [7:0] edge_select;
  logic [15:0] cmp [4];
  logic [15:0] cbuf [4];
  logic [15:0] next_cbuf [4];
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic armed;
  tpwm_state_e state;
  logic [7:0] div;
  logic [7:0] div_mask;
  logic trg_s1, trg_s2, trg_s3;
  logic evt_s1, evt_s2, evt_s3;
  logic trig_edge, evt_edge, sw_trig, trig;
  logic tick, running, step, wrap, reload, load_start;
  logic [2:0] raw;
  logic prim_tgl;
  logic [2:0] match;
  logic ce, eee, mode_pwm, mode_evt;

  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
    edge_hit = 1'b0;
    case (sel)
      TPWM_EDG_RISE: edge_hit = cur & ~prev;
      TPWM_EDG_FALL: edge_hit = prev & ~cur;
      TPWM_EDG_BOTH: edge_hit = cur ^ prev;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  assign ce = timer_control_zero[TPWM_B_CE];
  assign eee = timer_control_one[TPWM_B_EEE];
  assign mode_pwm = timer_control_one[TPWM_B_MD +: 3] == TPWM_MD_PWM;
  assign mode_evt = timer_control_one[TPWM_B_MD +: 3] == TPWM_MD_EVENT;

  // register writes
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      timer_control_zero <= TPWM_RST_REG8;
      timer_control_one <= TPWM_RST_REG8;
      output_control <= TPWM_RST_REG8;
      edge_select <= TPWM_RST_REG8;
      for (int i = 0; i < 4; i++)
        cmp[i] <= TPWM_RST_CMP;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        TPWM_A_CTL0: timer_control_zero <= reg_wdata[7:0] & 8'h87;
        // trigger bit is write-only, never stored
        TPWM_A_CTL1: timer_control_one <= reg_wdata[7:0] & 8'h27;
        TPWM_A_OUTC: output_control <= reg_wdata[7:0];
        TPWM_A_EDGE: edge_select <= reg_wdata[7:0] & 8'h0f;
        TPWM_A_CMP0: cmp[0] <= reg_wdata;
        TPWM_A_CMP1: cmp[1] <= reg_wdata;
        TPWM_A_CMP2: cmp[2] <= reg_wdata;
        TPWM_A_CMP3: cmp[3] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      reg_rdata <= TPWM_CNT_ZERO;
    else if (reg_rd)
    begin
      case (reg_addr)
        TPWM_A_CTL0: reg_rdata <= {8'h00, timer_control_zero};
        TPWM_A_CTL1: reg_rdata <= {8'h00, timer_control_one};
        TPWM_A_OUTC: reg_rdata <= {8'h00, output_control};
        TPWM_A_EDGE: reg_rdata <= {8'h00, edge_select};
        TPWM_A_CNT: reg_rdata <= cnt;
        TPWM_A_CMP0: reg_rdata <= cmp[0];
        TPWM_A_CMP1: reg_rdata <= cmp[1];
        TPWM_A_CMP2: reg_rdata <= cmp[2];
        TPWM_A_CMP3: reg_rdata <= cmp[3];
        default: reg_rdata <= TPWM_CNT_ZERO;
      endcase
    end
    else
      reg_rdata <= TPWM_CNT_ZERO;
  end

  // pin synchronisers, third stage only for edge detection
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      {trg_s1, trg_s2, trg_s3} <= 3'h0;
      {evt_s1, evt_s2, evt_s3} <= 3'h0;
    end
    else
    begin
      {trg_s1, trg_s2, trg_s3} <= {trigger_in, trg_s1, trg_s2};
      {evt_s1, evt_s2, evt_s3} <= {event_in, evt_s1, evt_s2};
    end
  end

  assign trig_edge = edge_hit(edge_select[TPWM_B_ETS +: 2], trg_s3, trg_s2);
  assign evt_edge = edge_hit(edge_select[TPWM_B_EES +: 2], evt_s3, evt_s2);
  assign sw_trig = reg_wr && reg_addr == TPWM_A_CTL1 && reg_wdata[TPWM_B_EST];
  // a trigger only matters in pwm mode with the enable set
  assign trig = (trig_edge | sw_trig) & ce & mode_pwm & (state != TPWM_ST_IDLE);

  // internal prescaler: divide by two to the clock select
  assign div_mask = (TPWM_DIV_ONE << timer_control_zero[TPWM_B_CKS +: 3]) - TPWM_DIV_ONE;
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || !ce)
      div <= 8'h00;
    else
      div <= div + 8'h01;
  end
  // event edges replace the prescaler when selected or in event mode
  assign tick = (eee | mode_evt) ? evt_edge : ((div & div_mask) == div_mask);

  assign running = state == TPWM_ST_RUN;
  assign step = tick & running & ~trig;
  assign wrap = step && cnt == cbuf[0];
  assign reload = wrap & armed;
  assign load_start = state == TPWM_ST_IDLE && ce && (mode_pwm || mode_evt);

  always_comb
  begin
    next_cnt = cnt;
    if (trig)
      next_cnt = TPWM_CNT_ZERO;
    else if (wrap)
      next_cnt = TPWM_CNT_ZERO;
    else if (step)
      next_cnt = cnt + 16'h0001;
    for (int i = 0; i < 4; i++)
      next_cbuf[i] = (reload || load_start) ? cmp[i] : cbuf[i];
  end

  // a match only counts when the counter steps onto the buffer value
  always_comb
  begin
    for (int k = 0; k < 3; k++)
      match[k] = step && next_cnt == next_cbuf[k + 1];
  end

  // state machine and counter
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state <= TPWM_ST_IDLE;
      cnt <= TPWM_CNT_IDLE;
    end
    else if (!ce)
    begin
      state <= TPWM_ST_IDLE;
      cnt <= TPWM_CNT_IDLE;
    end
    else
    begin
      case (state)
        TPWM_ST_IDLE:
        begin
          cnt <= TPWM_CNT_IDLE;
          if (mode_pwm)
            state <= TPWM_ST_WAIT;
          else if (mode_evt)
          begin
            state <= TPWM_ST_RUN;
            cnt <= TPWM_CNT_ZERO;
          end
        end
        TPWM_ST_WAIT:
        begin
          if (!mode_pwm)
            state <= TPWM_ST_IDLE;
          else if (trig)
          begin
            state <= TPWM_ST_RUN;
            cnt <= next_cnt;
          end
        end
        TPWM_ST_RUN:
        begin
          if (!mode_pwm && !mode_evt)
            state <= TPWM_ST_IDLE;
          cnt <= next_cnt;
        end
        default: state <= TPWM_ST_IDLE;
      endcase
    end
  end

  // compare buffers and reload arming; a write in the wrap cycle stays armed
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      armed <= 1'b0;
      for (int i = 0; i < 4; i++)
        cbuf[i] <= TPWM_RST_CMP;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
        cbuf[i] <= next_cbuf[i];
      if (reg_wr && reg_addr == TPWM_A_CMP1)
        armed <= 1'b1;
      else if (reload || load_start)
        armed <= 1'b0;
    end
  end

  // raw waveforms before level and enable
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || !ce || state == TPWM_ST_IDLE)
    begin
      raw <= 3'h0;
      prim_tgl <= 1'b0;
    end
    else
    begin
      if (trig)
      begin
        raw <= 3'h7;
        // first trigger does not toggle, a retrigger does
        prim_tgl <= prim_tgl ^ running;
      end
      else
      begin
        if (wrap)
          prim_tgl <= ~prim_tgl;
        for (int k = 0; k < 3; k++)
        begin
          if (match[k])
            raw[k] <= 1'b0;
          else if (wrap)
            raw[k] <= 1'b1;
        end
      end
    end
  end

  // registered outputs; pins lag the waveform by one clock
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      primary_output_pin <= 1'b0;
      secondary_output_pin <= 3'h0;
      period_match_irq <= 1'b0;
      width_match_irq <= 3'h0;
    end
    else
    begin
      primary_output_pin <= output_control[TPWM_B_OE0] ? prim_tgl
                            : output_control[TPWM_B_OL0];
      for (int k = 0; k < 3; k++)
        secondary_output_pin[k] <= output_control[2 * k + 2]
                                   & (raw[k] ^ output_control[2 * k + 3]);
      period_match_irq <= wrap;
      width_match_irq <= match;
    end
  end

  // checks
  AST_WAIT_IDLE_CNT: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state == TPWM_ST_WAIT |-> cnt == TPWM_CNT_IDLE)
    else $error("counter moved while waiting for trigger");
  AST_WAIT_MODE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(state == TPWM_ST_WAIT) |-> $past(mode_pwm))
    else $error("trigger wait entered outside pwm mode");
  AST_TRIG_START: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state == TPWM_ST_WAIT && trig
    |=> state == TPWM_ST_RUN && cnt == TPWM_CNT_ZERO)
    else $error("first trigger did not start counter at zero");
  AST_RETRIG: assert property (@(posedge clk_sys) disable iff (sys_rst)
    running && trig
    |=> cnt == TPWM_CNT_ZERO && raw == 3'h7 && prim_tgl != $past(prim_tgl))
    else $error("retrigger did not restart counter and outputs");
  AST_PERIOD_IRQ: assert property (@(posedge clk_sys) disable iff (sys_rst)
    // a zero period wraps on every tick, so the pulse may legally repeat
    step && cnt == cbuf[0] && ce && !reg_wr && next_cbuf[0] != TPWM_CNT_ZERO
    |=> period_match_irq && cnt == TPWM_CNT_ZERO ##1 !period_match_irq)
    else $error("period match did not clear counter with irq");
  AST_WIDTH_IRQ: assert property (@(posedge clk_sys) disable iff (sys_rst)
    width_match_irq[0] |-> cnt == cbuf[1] && !raw[0])
    else $error("width irq without counter equal to buffer");
  AST_NO_IRQ_ABOVE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    width_match_irq[1] |-> cbuf[2] <= cbuf[0])
    else $error("width irq raised with buffer above period");
  AST_RELOAD: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reload && ce |=> cbuf[0] == $past(cmp[0]) && cbuf[2] == $past(cmp[2]))
    else $error("buffers not reloaded at wrap");
  AST_NO_RELOAD: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state != TPWM_ST_IDLE && !armed |=> cbuf[2] == $past(cbuf[2]))
    else $error("buffer changed without compare one write");
  AST_STOP: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !ce |=> state == TPWM_ST_IDLE && cnt == TPWM_CNT_IDLE)
    else $error("clearing enable did not stop counter");
  AST_PRIM_IDLE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !output_control[TPWM_B_OE0] |=> primary_output_pin == $past(output_control[TPWM_B_OL0]))
    else $error("disabled primary pin not at idle level");
  AST_SEC_LEVEL: assert property (@(posedge clk_sys) disable iff (sys_rst)
    output_control[2] |=> secondary_output_pin[0] == ($past(raw[0]) ^ $past(output_control[3])))
    else $error("secondary pin level wrong");
  AST_CNT_READ: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_rd && reg_addr == TPWM_A_CNT |=> reg_rdata == $past(cnt))
    else $error("counter readback mismatch");
  COV_RETRIG: cover property (@(posedge clk_sys) disable iff (sys_rst)
    running && trig);
  COV_WRAP_RELOAD: cover property (@(posedge clk_sys) disable iff (sys_rst)
    reload);
  COV_WIDTH: cover property (@(posedge clk_sys) disable iff (sys_rst)
    width_match_irq[0] ##[1:50] period_match_irq);
  COV_SW_TRIG: cover property (@(posedge clk_sys) disable iff (sys_rst)
    state == TPWM_ST_WAIT && sw_trig);
endmodule

// ==== tb/tpwm_trig_src.sv ====
// trigger source model driving the external trigger pin
`timescale 1ns/1ps
module tpwm_trig_src
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // command from the bench
  input wire logic fire,
  // trigger pin
  output logic trigger_in
);
  logic [2:0] hold;
  // held several clocks so the two-flop synchroniser cannot miss it
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      hold <= 3'h0;
    else if (fire)
      hold <= 3'h4;
    else if (hold != 3'h0)
      hold <= hold - 3'h1;
  end
  assign trigger_in = (hold != 3'h0);
endmodule

// ==== tb/tb_tpwm_timer.sv ====
// self-checking bench for the triggered pwm timer
`timescale 1ns/1ps
module tb_tpwm_timer;
  import tpwm_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic trigger_in;
  logic event_in = 1'b0;
  logic fire = 1'b0;
  logic primary_output_pin;
  logic [2:0] secondary_output_pin;
  logic period_match_irq;
  logic [2:0] width_match_irq;
  int n_fail = 0;
  int compares = 0;
  logic [15:0] n_pirq, n_tog, rd_val;
  logic [15:0] n_wirq [3];
  logic [15:0] n_high [3];
  logic mon_on = 1'b0;
  logic prim_q = 1'b0;

  initial
  begin
    forever #10 clk_sys = ~clk_sys;
  end

  tpwm_timer DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .trigger_in(trigger_in), .event_in(event_in), .primary_output_pin(primary_output_pin),
    .secondary_output_pin(secondary_output_pin), .period_match_irq(period_match_irq),
    .width_match_irq(width_match_irq));
  tpwm_trig_src src (.clk_sys(clk_sys), .sys_rst(sys_rst), .fire(fire),
    .trigger_in(trigger_in));

  // counts over whole periods, so the one-cycle pin lag does not matter
  always @(posedge clk_sys)
  begin
    if (mon_on)
    begin
      n_pirq += (period_match_irq === 1'b1);
      n_tog += (primary_output_pin !== prim_q);
      for (int k = 0; k < 3; k++)
      begin
        n_wirq[k] += (width_match_irq[k] === 1'b1);
        n_high[k] += (secondary_output_pin[k] === 1'b1);
      end
    end
    prim_q <= primary_output_pin;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    // idle cycle so a following write never lowers and raises the strobe at once
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    rd_val = reg_rdata;
  endtask

  task automatic wait_pirq();
    int i;
    i = 0;
    do
    begin
      @(posedge clk_sys);
      i++;
    end while (period_match_irq !== 1'b1 && i < 200);
    if (i >= 200)
    begin
      n_fail++;
      $display("ERROR period_irq expected 1 seen 0");
    end
  endtask

  task automatic window(input int n);
    n_pirq = 16'h0000;
    n_tog = 16'h0000;
    n_wirq = '{16'h0000, 16'h0000, 16'h0000};
    n_high = '{16'h0000, 16'h0000, 16'h0000};
    mon_on <= 1'b1;
    repeat (n) @(posedge clk_sys);
    mon_on <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic fire_pin();
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rd(TPWM_A_CNT);
  endtask

  task automatic t_regs();
    rd(TPWM_A_CNT);
    check("cnt_reset", rd_val, TPWM_CNT_IDLE);
    rd(TPWM_A_OUTC);
    check("outc_reset", rd_val, 16'h0000);
    wr(TPWM_A_EDGE, 16'h0009);
    rd(TPWM_A_EDGE);
    check("edge_rw", rd_val, 16'h0009);
    wr(TPWM_A_CTL1, 16'h0042);
    rd(TPWM_A_CTL1);
    check("ctl1_rw", rd_val, 16'h0002);
    rd(4'hf);
    check("unmapped", rd_val, 16'h0000);
    $display("t_regs done");
  endtask

  task automatic t_pwm();
    wr(TPWM_A_OUTC, 16'h00d5);
    wr(TPWM_A_EDGE, 16'h0000);
    wr(TPWM_A_CMP0, 16'h0009);
    wr(TPWM_A_CMP2, 16'h000c);
    wr(TPWM_A_CMP3, 16'h0005);
    wr(TPWM_A_CMP1, 16'h0003);
    wr(TPWM_A_CTL1, {13'h0000, TPWM_MD_PWM});
    wr(TPWM_A_CTL0, 16'h0080);
    repeat (20) @(posedge clk_sys);
    rd(TPWM_A_CNT);
    check("cnt_waiting", rd_val, TPWM_CNT_IDLE);
    wr(TPWM_A_CTL1, 16'h0042);
    rd(TPWM_A_CNT);
    check("cnt_started", {15'h0000, rd_val <= 16'h0003}, 16'h0001);
    wait_pirq();
    window(40);
    check("pirq", n_pirq, 16'h0004);
    check("toggles", n_tog, 16'h0004);
    check("wirq_a", n_wirq[0], 16'h0004);
    check("wirq_b", n_wirq[1], 16'h0000);
    check("wirq_c", n_wirq[2], 16'h0004);
    check("high_a", n_high[0], 16'h000c);
    check("high_b", n_high[1], 16'h0028);
    check("high_c", n_high[2], 16'h0014);
    $display("t_pwm done");
  endtask

  task automatic t_retrig();
    logic prim;
    wait_pirq();
    repeat (5) @(posedge clk_sys);
    prim = primary_output_pin;
    wr(TPWM_A_CTL1, 16'h0042);
    repeat (2) @(posedge clk_sys);
    check("sec_retrig", {13'h0000, secondary_output_pin}, 16'h0003);
    check("prim_retrig", {15'h0000, primary_output_pin}, {15'h0000, ~prim});
    wr(TPWM_A_CTL0, 16'h0000);
    rd(TPWM_A_CNT);
    check("cnt_stop_now", rd_val, TPWM_CNT_IDLE);
    repeat (12) @(posedge clk_sys);
    rd(TPWM_A_CNT);
    check("cnt_stopped", rd_val, TPWM_CNT_IDLE);
    wr(TPWM_A_CTL0, 16'h0081);
    fire_pin();
    check("edge_none", rd_val, TPWM_CNT_IDLE);
    wr(TPWM_A_EDGE, {14'h0000, TPWM_EDG_RISE});
    fire_pin();
    check("ext_start", {15'h0000, rd_val <= 16'h0008}, 16'h0001);
    $display("t_retrig done");
  endtask

  task automatic t_reload();
    wr(TPWM_A_CMP0, 16'h0004);
    wait_pirq();
    wait_pirq();
    window(80);
    check("period_unarmed", n_pirq, 16'h0004);
    wr(TPWM_A_CMP1, 16'h0003);
    wait_pirq();
    wait_pirq();
    window(40);
    check("period_new", n_pirq, 16'h0004);
    check("high_a_new", n_high[0], 16'h0018);
    $display("t_reload done");
  endtask

  task automatic t_idle();
    wr(TPWM_A_CTL0, 16'h0000);
    wr(TPWM_A_OUTC, 16'h0002);
    wr(TPWM_A_CTL1, 16'h0003);
    wr(TPWM_A_CTL0, 16'h0080);
    wr(TPWM_A_CTL1, 16'h0043);
    rd(TPWM_A_CNT);
    check("mode_other_now", rd_val, TPWM_CNT_IDLE);
    repeat (10) @(posedge clk_sys);
    check("prim_idle", {15'h0000, primary_output_pin}, 16'h0001);
    check("sec_off", {13'h0000, secondary_output_pin}, 16'h0000);
    rd(TPWM_A_CNT);
    check("mode_other", rd_val, TPWM_CNT_IDLE);
    $display("t_idle done");
  endtask

  task automatic t_event();
    wr(TPWM_A_CTL0, 16'h0000);
    wr(TPWM_A_EDGE, {12'h000, TPWM_EDG_RISE, 2'h0});
    wr(TPWM_A_CMP0, 16'h0003);
    wr(TPWM_A_CMP2, 16'h0007);
    wr(TPWM_A_CMP3, 16'h0002);
    wr(TPWM_A_CMP1, 16'h0001);
    wr(TPWM_A_CTL1, {13'h0000, TPWM_MD_EVENT});
    wr(TPWM_A_CTL0, 16'h0080);
    n_pirq = 16'h0000;
    n_wirq = '{16'h0000, 16'h0000, 16'h0000};
    mon_on <= 1'b1;
    // one rising edge every four clocks, slow enough for the synchroniser
    repeat (16)
    begin
      event_in <= 1'b1;
      repeat (2) @(posedge clk_sys);
      event_in <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
    repeat (6) @(posedge clk_sys);
    mon_on <= 1'b0;
    @(posedge clk_sys);
    check("ev_pirq", n_pirq, 16'h0004);
    check("ev_wirq_a", n_wirq[0], 16'h0004);
    check("ev_wirq_b", n_wirq[1], 16'h0000);
    check("ev_wirq_c", n_wirq[2], 16'h0004);
    rd(TPWM_A_CNT);
    check("ev_cnt", rd_val, TPWM_CNT_ZERO);
    $display("t_event done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs();
    t_pwm();
    t_retrig();
    t_reload();
    t_idle();
    t_event();
    final_report();
  end

  // whole run is well under two thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    final_report();
  end
endmodule
